// ---- core/dmb_pkg.sv ----
// Shared constants, types and helpers for the dual memory bus port.
package dmb_pkg;
    localparam int CA_BYTES = 6;
    localparam int CA_W = 48;
    localparam int CA_READ_BIT = 47;
    localparam int LAT_CYCLES = 6;
    localparam int EDGES_PER_CYCLE = 2;
    localparam int EXTRA_FACTOR = 2;
    localparam int HALF_DIV = 8;
    localparam int END_HOLD = 16;
    localparam int CNT_W = 16;
    localparam int POR_W = 16;
    localparam logic DIE_FLASH = 1'b0;
    localparam logic DIE_DRAM = 1'b1;
    localparam int DEV_PINS = 13;
    localparam int PIN_HWRST = 12;
    localparam int PIN_CK = 11;
    localparam int PIN_FSEL = 10;
    localparam int PIN_DSEL = 9;
    localparam int PIN_READ_WRITE_STROBE_MASK = 8;
    localparam logic [DEV_PINS-1:0] DEV_PIN_IDLE = 13'h16FF;
    localparam int HOST_PINS = 9;
    localparam logic [HOST_PINS-1:0] HOST_PIN_IDLE = 9'h0FF;
    localparam logic [7:0] DQ_PULL = 8'hFF;
    localparam logic READ_WRITE_STROBE_MASK_PULL = 1'b0;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CA_EDGES = 16'h0006;
    localparam logic [CNT_W-1:0] CA_LAST = 16'h0005;

    typedef enum logic [1:0] {
        dmb_d_idle = 2'b00,
        dmb_d_ca = 2'b01,
        dmb_d_lat = 2'b11,
        dmb_d_data = 2'b10
    } dmb_dev_state_t;

    typedef enum logic [2:0] {
        dmb_h_idle = 3'b000,
        dmb_h_ca = 3'b001,
        dmb_h_lat = 3'b011,
        dmb_h_data = 3'b010,
        dmb_h_end = 3'b110
    } dmb_host_state_t;

    // Initial latency in link edges; an extra request doubles it.
    function automatic logic [CNT_W-1:0] dmb_lat_edges(input logic extra, input int lat);
        int e;
        e = lat * EDGES_PER_CYCLE;
        if (extra) begin
            e = e * EXTRA_FACTOR;
        end
        return e[CNT_W-1:0];
    endfunction

    // Majority of the second and third synchroniser stages, else hold.
    function automatic logic [DEV_PINS-1:0] dmb_settle(input logic [DEV_PINS-1:0] s1,
            input logic [DEV_PINS-1:0] s2, input logic [DEV_PINS-1:0] held);
        return (~(s1 ^ s2) & s2) | ((s1 ^ s2) & held);
    endfunction
endpackage

// ---- core/dmb_bus_if.sv ----
// Shared bus wires between the host controller and the two-die memory.
`timescale 1ns/1ns
interface dmb_bus_if;
    import dmb_pkg::*;
    logic ck;
    logic clock_complement;
    logic flash_select_n;
    logic dram_select_n;
    logic hw_reset_n;
    logic [7:0] host_dq_o;
    logic host_dq_oe;
    logic host_read_write_strobe_mask_o;
    logic host_read_write_strobe_mask_oe;
    logic [7:0] dev_dq_o;
    logic dev_dq_oe;
    logic dev_read_write_strobe_mask_o;
    logic dev_read_write_strobe_mask_oe;
    logic int_oe;
    logic power_on_reset_out_n_oe;
    logic [7:0] dq;
    logic read_write_strobe_mask;
    logic flash_interrupt_n;
    logic power_on_reset_out_n;

    // Undriven lines settle to their pull levels.
    assign dq = dev_dq_oe ? dev_dq_o : (host_dq_oe ? host_dq_o : DQ_PULL);
    assign read_write_strobe_mask = dev_read_write_strobe_mask_oe ? dev_read_write_strobe_mask_o
                                  : (host_read_write_strobe_mask_oe ? host_read_write_strobe_mask_o : READ_WRITE_STROBE_MASK_PULL);
    assign flash_interrupt_n = ~int_oe;
    assign power_on_reset_out_n = ~power_on_reset_out_n_oe;

    modport host (
        output ck, clock_complement, flash_select_n, dram_select_n, hw_reset_n,
        output host_dq_o, host_dq_oe, host_read_write_strobe_mask_o, host_read_write_strobe_mask_oe,
        input dq, read_write_strobe_mask, flash_interrupt_n, power_on_reset_out_n
    );
    modport device (
        input ck, clock_complement, flash_select_n, dram_select_n, hw_reset_n,
        output dev_dq_o, dev_dq_oe, dev_read_write_strobe_mask_o, dev_read_write_strobe_mask_oe, int_oe, power_on_reset_out_n_oe,
        input dq, read_write_strobe_mask
    );
endinterface

// ---- core/dmb_host_end.sv ----
// Host controller end: clock divider, selects, command, latency and data.
`timescale 1ns/1ns
module dmb_host_end
    import dmb_pkg::*;
#(
    parameter int HALF = HALF_DIV,
    parameter int LAT = LAT_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    dmb_bus_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_die,
    input wire logic cmd_read,
    input wire logic [CA_W-1:0] cmd_ca,
    input wire logic [CNT_W-1:0] cmd_len,
    input wire logic [7:0] wr_data,
    input wire logic wr_mask,
    output logic wr_req,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic done,
    output logic extra_seen,
    input wire logic hw_reset_req
);
    localparam logic [CNT_W-1:0] DIV_MID = CNT_W'(HALF / 2 - 1);
    localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(HALF - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(END_HOLD - 1);

    dmb_host_state_t state_q;
    logic [HOST_PINS-1:0] s0_q, s1_q, s2_q, pin_q, prev_q;
    logic [CNT_W-1:0] div_q, ecnt_q, len_q, rcnt_q, lat_e, ecnt_n;
    logic [CA_W-1:0] ca_q;
    logic die_q, read_q, ck_q, sel_q;
    logic tick_mid, tick_edge;

    ////////////////////////////////////////////////////////////////////////
    // Returned strobe and data pass three flops before use.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s0_q <= HOST_PIN_IDLE;
            s1_q <= HOST_PIN_IDLE;
            s2_q <= HOST_PIN_IDLE;
            pin_q <= HOST_PIN_IDLE;
            prev_q <= HOST_PIN_IDLE;
        end else begin
            s0_q <= {bus.read_write_strobe_mask, bus.dq};
            s1_q <= s0_q;
            s2_q <= s1_q;
            pin_q <= (~(s1_q ^ s2_q) & s2_q) | ((s1_q ^ s2_q) & pin_q);
            prev_q <= pin_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The clock only runs inside a frame and stays far below either limit.
    assign tick_mid = (div_q == DIV_MID);
    assign tick_edge = (div_q == DIV_LAST);
    assign lat_e = dmb_lat_edges(extra_seen, LAT);
    assign ecnt_n = ecnt_q + CNT_ONE;
    assign cmd_ready = (state_q == dmb_h_idle);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= dmb_h_idle;
            div_q <= CNT_ZERO;
            ecnt_q <= CNT_ZERO;
            ck_q <= 1'b0;
            sel_q <= 1'b0;
            die_q <= DIE_FLASH;
            read_q <= 1'b0;
            len_q <= CNT_ZERO;
            extra_seen <= 1'b0;
        end else begin
            case (state_q)
                dmb_h_idle: begin
                    // The clock parks where the frame left it, so it never moves while deselected.
                    div_q <= CNT_ZERO;
                    ecnt_q <= CNT_ZERO;
                    if (cmd_valid) begin
                        state_q <= dmb_h_ca;
                        sel_q <= 1'b1;
                        die_q <= cmd_die;
                        read_q <= cmd_read;
                        len_q <= cmd_len;
                    end
                end
                dmb_h_ca, dmb_h_lat, dmb_h_data: begin
                    div_q <= tick_edge ? CNT_ZERO : div_q + CNT_ONE;
                    if (tick_edge) begin
                        ck_q <= ~ck_q;
                        ecnt_q <= ecnt_n;
                        if (ecnt_q == CA_LAST) begin
                            extra_seen <= pin_q[8];
                        end
                        if (ecnt_n == CA_EDGES + lat_e + len_q && state_q != dmb_h_ca) begin
                            state_q <= dmb_h_end;
                            div_q <= CNT_ZERO;
                        end else if (ecnt_n == CA_EDGES + lat_e && state_q == dmb_h_lat) begin
                            state_q <= dmb_h_data;
                        end else if (ecnt_n == CA_EDGES) begin
                            state_q <= dmb_h_lat;
                        end
                    end
                end
                dmb_h_end: begin
                    div_q <= div_q + CNT_ONE;
                    if (div_q == HOLD_LAST) begin
                        state_q <= dmb_h_idle;
                        sel_q <= 1'b0;
                    end
                end
                default: state_q <= dmb_h_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outgoing bytes change mid half-period so the far end sees them settled.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ca_q <= '0;
            bus.host_dq_o <= DQ_PULL;
            bus.host_dq_oe <= 1'b0;
            bus.host_read_write_strobe_mask_o <= 1'b0;
            bus.host_read_write_strobe_mask_oe <= 1'b0;
            wr_req <= 1'b0;
        end else begin
            wr_req <= 1'b0;
            if (state_q == dmb_h_idle) begin
                ca_q <= {cmd_read, cmd_ca[CA_READ_BIT-1:0]};
            end
            if (state_q == dmb_h_ca && tick_mid) begin
                bus.host_dq_o <= ca_q[CA_W-1 -: 8];
                bus.host_dq_oe <= 1'b1;
                ca_q <= {ca_q[CA_W-9:0], 8'h00};
            end else if (state_q == dmb_h_data && tick_mid && !read_q) begin
                bus.host_dq_o <= wr_data;
                bus.host_dq_oe <= 1'b1;
                bus.host_read_write_strobe_mask_o <= wr_mask;
                bus.host_read_write_strobe_mask_oe <= (die_q == DIE_DRAM);
                wr_req <= 1'b1;
            end else if (state_q == dmb_h_lat || state_q == dmb_h_end
                         || (read_q && state_q != dmb_h_ca)) begin
                // A back-to-back frame must not drive before the last reader has let go.
                bus.host_dq_oe <= 1'b0;
                bus.host_read_write_strobe_mask_oe <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read bytes are taken on settled strobe changes in the data and end states, up to the requested length.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
            rcnt_q <= CNT_ZERO;
            done <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            done <= (state_q == dmb_h_end) && (div_q == HOLD_LAST);
            if (state_q == dmb_h_idle) begin
                rcnt_q <= CNT_ZERO;
            end else if (read_q && (state_q == dmb_h_data || state_q == dmb_h_end)
                         && (pin_q[8] != prev_q[8]) && rcnt_q != len_q) begin
                rd_valid <= 1'b1;
                rd_data <= pin_q[7:0];
                rcnt_q <= rcnt_q + CNT_ONE;
            end
        end
    end

    // Only one select is ever low at a time.
    assign bus.flash_select_n = ~(sel_q && die_q == DIE_FLASH);
    assign bus.dram_select_n = ~(sel_q && die_q == DIE_DRAM);
    assign bus.ck = ck_q;
    assign bus.clock_complement = ~ck_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            bus.hw_reset_n <= 1'b1;
        end else begin
            bus.hw_reset_n <= ~hw_reset_req;
        end
    end
endmodule

// ---- core/dmb_dev_end.sv ----
// Memory package end: select decode, framing, latency, strobe, flash extras.
`timescale 1ns/1ns
module dmb_dev_end
    import dmb_pkg::*;
#(
    parameter int LAT = LAT_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    dmb_bus_if.device bus,
    input wire logic extra_latency,
    input wire logic flash_busy,
    input wire logic [POR_W-1:0] por_timeout,
    input wire logic [7:0] rd_data,
    output logic rd_req,
    output logic txn_start,
    output logic txn_end,
    output logic txn_read,
    output logic txn_die,
    output logic [CA_W-1:0] txn_ca,
    output logic wr_valid,
    output logic [7:0] wr_data,
    output logic wr_mask,
    output logic flash_ready
);
    dmb_dev_state_t state_q;
    logic [DEV_PINS-1:0] s0_q, s1_q, s2_q, pin_q, prev_q;
    logic [CNT_W-1:0] ecnt_q, lat_e;
    logic [CA_W-1:0] ca_q;
    logic die_q, read_q, extra_q;
    logic ck_edge, fsel_fall, dsel_fall, sel_rise, abort;
    logic [POR_W-1:0] por_cnt_q;
    logic por_done_q, busy_prev_q, int_q;

    ////////////////////////////////////////////////////////////////////////
    // Every bus input but clock_complement is foreign to core_clk and passes three flops.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s0_q <= DEV_PIN_IDLE;
            s1_q <= DEV_PIN_IDLE;
            s2_q <= DEV_PIN_IDLE;
            pin_q <= DEV_PIN_IDLE;
            prev_q <= DEV_PIN_IDLE;
        end else begin
            s0_q <= {bus.hw_reset_n, bus.ck, bus.flash_select_n, bus.dram_select_n,
                     bus.read_write_strobe_mask, bus.dq};
            s1_q <= s0_q;
            s2_q <= s1_q;
            pin_q <= dmb_settle(s1_q, s2_q, pin_q);
            prev_q <= pin_q;
        end
    end

    // A 1.8V pair is taken as its true phase: each crossing is one of its edges.
    assign ck_edge = pin_q[PIN_CK] ^ prev_q[PIN_CK];
    assign fsel_fall = prev_q[PIN_FSEL] & ~pin_q[PIN_FSEL];
    assign dsel_fall = prev_q[PIN_DSEL] & ~pin_q[PIN_DSEL];
    assign sel_rise = (die_q == DIE_DRAM) ? (pin_q[PIN_DSEL] & ~prev_q[PIN_DSEL])
                                          : (pin_q[PIN_FSEL] & ~prev_q[PIN_FSEL]);
    assign abort = sel_rise || (die_q == DIE_FLASH && !flash_ready);
    assign lat_e = dmb_lat_edges(extra_q, LAT);
    assign flash_ready = por_done_q && pin_q[PIN_HWRST];

    ////////////////////////////////////////////////////////////////////////
    // Framing. The host keeps one select low at a time, so one die is active.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= dmb_d_idle;
            die_q <= DIE_FLASH;
            read_q <= 1'b0;
            extra_q <= 1'b0;
            ecnt_q <= CNT_ZERO;
            ca_q <= '0;
        end else begin
            case (state_q)
                dmb_d_idle: begin
                    ecnt_q <= CNT_ZERO;
                    if (fsel_fall && flash_ready) begin
                        state_q <= dmb_d_ca;
                        die_q <= DIE_FLASH;
                        extra_q <= extra_latency;
                    end else if (dsel_fall) begin
                        state_q <= dmb_d_ca;
                        die_q <= DIE_DRAM;
                        extra_q <= extra_latency;
                    end
                end
                dmb_d_ca: begin
                    if (abort) begin
                        state_q <= dmb_d_idle;
                    end else if (ck_edge) begin
                        ca_q <= {ca_q[CA_W-9:0], pin_q[7:0]};
                        ecnt_q <= ecnt_q + CNT_ONE;
                        if (ecnt_q == CA_LAST) begin
                            state_q <= dmb_d_lat;
                            read_q <= ca_q[CA_W-9];
                            ecnt_q <= CNT_ZERO;
                        end
                    end
                end
                dmb_d_lat: begin
                    if (abort) begin
                        state_q <= dmb_d_idle;
                    end else if (ck_edge) begin
                        ecnt_q <= ecnt_q + CNT_ONE;
                        if (ecnt_q == lat_e - CNT_ONE) begin
                            state_q <= dmb_d_data;
                        end
                    end
                end
                dmb_d_data: begin
                    if (abort) begin
                        state_q <= dmb_d_idle;
                    end
                end
                default: state_q <= dmb_d_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line drivers. Strobe shows latency, then read timing, else is released.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bus.dev_dq_o <= DQ_PULL;
            bus.dev_dq_oe <= 1'b0;
            bus.dev_read_write_strobe_mask_o <= 1'b0;
            bus.dev_read_write_strobe_mask_oe <= 1'b0;
            rd_req <= 1'b0;
        end else begin
            rd_req <= 1'b0;
            if (state_q != dmb_d_idle && abort) begin
                bus.dev_dq_oe <= 1'b0;
                bus.dev_read_write_strobe_mask_oe <= 1'b0;
            end else if (state_q == dmb_d_idle && ((fsel_fall && flash_ready) || dsel_fall)) begin
                bus.dev_read_write_strobe_mask_oe <= 1'b1;
                bus.dev_read_write_strobe_mask_o <= extra_latency;
            end else if (state_q == dmb_d_ca && ck_edge && ecnt_q == CA_LAST) begin
                bus.dev_read_write_strobe_mask_o <= 1'b0;
                bus.dev_read_write_strobe_mask_oe <= ca_q[CA_W-9];
            end else if (state_q == dmb_d_data && read_q && ck_edge) begin
                bus.dev_dq_o <= rd_data;
                bus.dev_dq_oe <= 1'b1;
                bus.dev_read_write_strobe_mask_o <= ~bus.dev_read_write_strobe_mask_o;
                rd_req <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // User side pulses for command, write bytes and the end of a frame.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            txn_start <= 1'b0;
            txn_end <= 1'b0;
            txn_read <= 1'b0;
            txn_die <= DIE_FLASH;
            txn_ca <= '0;
            wr_valid <= 1'b0;
            wr_data <= 8'h00;
            wr_mask <= 1'b0;
        end else begin
            txn_start <= 1'b0;
            wr_valid <= 1'b0;
            txn_end <= (state_q != dmb_d_idle) && abort;
            if (state_q == dmb_d_ca && ck_edge && ecnt_q == CA_LAST && !abort) begin
                txn_start <= 1'b1;
                txn_ca <= {ca_q[CA_W-9:0], pin_q[7:0]};
                txn_read <= ca_q[CA_W-9];
                txn_die <= die_q;
            end
            if (state_q == dmb_d_data && !read_q && ck_edge && !abort) begin
                wr_valid <= 1'b1;
                wr_data <= pin_q[7:0];
                wr_mask <= (die_q == DIE_DRAM) && pin_q[PIN_READ_WRITE_STROBE_MASK];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-on reset output held low for the user timeout after reset.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            por_cnt_q <= '0;
            por_done_q <= 1'b0;
        end else if (!por_done_q) begin
            por_cnt_q <= por_cnt_q + POR_W'(1);
            if (por_cnt_q >= por_timeout) begin
                por_done_q <= 1'b1;
            end
        end
    end

    assign bus.power_on_reset_out_n_oe = ~por_done_q;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt stays low until the next flash frame; a new event wins.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            busy_prev_q <= 1'b0;
            int_q <= 1'b0;
        end else begin
            busy_prev_q <= flash_busy;
            if (busy_prev_q && !flash_busy) begin
                int_q <= 1'b1;
            end else if (state_q == dmb_d_idle && fsel_fall && flash_ready) begin
                int_q <= 1'b0;
            end
        end
    end

    assign bus.int_oe = int_q;
endmodule

// ---- verification/dmb_bus_asserts.sv ----
// Concurrent checks on the shared memory bus wires.
`timescale 1ns/1ns
module dmb_bus_asserts (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ck,
    input wire logic clock_complement,
    input wire logic flash_select_n,
    input wire logic dram_select_n,
    input wire logic hw_reset_n,
    input wire logic host_dq_oe,
    input wire logic host_read_write_strobe_mask_oe,
    input wire logic [7:0] dev_dq_o,
    input wire logic dev_dq_oe,
    input wire logic dev_read_write_strobe_mask_o,
    input wire logic dev_read_write_strobe_mask_oe,
    input wire logic int_oe,
    input wire logic power_on_reset_out_n_oe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    a_one_select: assert property (flash_select_n || dram_select_n)
        else $error("both selects low");
    a_pair_phase: assert property (clock_complement == ~ck)
        else $error("clock pair not complementary");
    a_ck_rate: assert property ($changed(ck) |=> $stable(ck))
        else $error("link clock toggles too fast");
    a_ck_still: assert property (flash_select_n && dram_select_n |-> $stable(ck))
        else $error("link clock moved outside a frame");
    a_no_clash: assert property (!(host_dq_oe && dev_dq_oe) && !(host_read_write_strobe_mask_oe && dev_read_write_strobe_mask_oe))
        else $error("both ends drive a line");
    a_idle_quiet: assert property ((flash_select_n && dram_select_n) [*8] |->
        !dev_dq_oe && !dev_read_write_strobe_mask_oe) else $error("device drives while deselected");
    a_dram_report: assert property ($fell(dram_select_n) |-> ##[1:8] dev_read_write_strobe_mask_oe)
        else $error("no latency report on dram frame");
    a_reset_quiet: assert property ((!hw_reset_n && dram_select_n) [*8] |->
        !dev_dq_oe && !dev_read_write_strobe_mask_oe) else $error("flash drives during reset");
    a_mask_dram: assert property (host_read_write_strobe_mask_oe |-> !dram_select_n)
        else $error("host mask drive outside dram frame");
    a_strobe_align: assert property ($past(dev_dq_oe) && dev_dq_oe && $changed(dev_dq_o)
        |-> $changed(dev_read_write_strobe_mask_o)) else $error("read byte without strobe edge");
    a_int_clear: assert property ($fell(int_oe) |-> !flash_select_n)
        else $error("interrupt cleared without flash frame");
    a_por_once: assert property ($fell(power_on_reset_out_n_oe) |=> !power_on_reset_out_n_oe [*8])
        else $error("reset output asserted again");
    c_dram_extra: cover property (!dram_select_n && dev_read_write_strobe_mask_oe && dev_read_write_strobe_mask_o);
    c_flash_read: cover property (!flash_select_n && dev_dq_oe);
    c_int_raise: cover property ($rose(int_oe));
endmodule

// ---- verification/dual_memory_ddr_bus_port_bench.sv ----
// Both bus ends joined back to back and driven through their user sides.
`timescale 1ns/1ns
module dual_memory_ddr_bus_port_bench;
    import dmb_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0, cmd_die = 1'b0, cmd_read = 1'b0, hw_reset_req = 1'b0;
    logic extra_latency = 1'b0, flash_busy = 1'b0;
    logic [CA_W-1:0] cmd_ca = 48'h0000_0000_0000;
    logic [CNT_W-1:0] cmd_len = 16'h0000;
    logic [POR_W-1:0] por_timeout = 16'h0014;
    logic [7:0] wr_data, dev_rd, h_rd, d_wr;
    logic wr_mask, cmd_ready, wr_req, rd_valid, done, extra_seen, rd_req, txn_start, txn_end;
    logic txn_read, txn_die, wr_valid, d_mask, flash_ready;
    logic [CA_W-1:0] txn_ca;
    int failures = 0, check_count = 0;
    int wi = 0, ri = 0, dwi = 0, hri = 0, starts = 0, ends = 0;
    assign wr_data = 8'hA0 + wi[7:0];
    assign wr_mask = wi[0];
    assign dev_rd = 8'h50 + ri[7:0];
    dmb_bus_if u_dmb_bus_if ();
    dmb_host_end u_dmb_host_end (.core_clk(core_clk), .reset(reset), .bus(u_dmb_bus_if),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_die(cmd_die), .cmd_read(cmd_read),
        .cmd_ca(cmd_ca), .cmd_len(cmd_len), .wr_data(wr_data), .wr_mask(wr_mask),
        .wr_req(wr_req), .rd_valid(rd_valid), .rd_data(h_rd), .done(done),
        .extra_seen(extra_seen), .hw_reset_req(hw_reset_req));
    dmb_dev_end u_dmb_dev_end (.core_clk(core_clk), .reset(reset), .bus(u_dmb_bus_if),
        .extra_latency(extra_latency), .flash_busy(flash_busy), .por_timeout(por_timeout),
        .rd_data(dev_rd), .rd_req(rd_req), .txn_start(txn_start), .txn_end(txn_end),
        .txn_read(txn_read), .txn_die(txn_die), .txn_ca(txn_ca), .wr_valid(wr_valid),
        .wr_data(d_wr), .wr_mask(d_mask), .flash_ready(flash_ready));
    dmb_bus_asserts u_dmb_bus_asserts (.core_clk(core_clk), .reset(reset),
        .ck(u_dmb_bus_if.ck), .clock_complement(u_dmb_bus_if.clock_complement),
        .flash_select_n(u_dmb_bus_if.flash_select_n),
        .dram_select_n(u_dmb_bus_if.dram_select_n), .hw_reset_n(u_dmb_bus_if.hw_reset_n),
        .host_dq_oe(u_dmb_bus_if.host_dq_oe), .host_read_write_strobe_mask_oe(u_dmb_bus_if.host_read_write_strobe_mask_oe),
        .dev_dq_o(u_dmb_bus_if.dev_dq_o), .dev_dq_oe(u_dmb_bus_if.dev_dq_oe),
        .dev_read_write_strobe_mask_o(u_dmb_bus_if.dev_read_write_strobe_mask_o), .dev_read_write_strobe_mask_oe(u_dmb_bus_if.dev_read_write_strobe_mask_oe),
        .int_oe(u_dmb_bus_if.int_oe), .power_on_reset_out_n_oe(u_dmb_bus_if.power_on_reset_out_n_oe));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Every wait after reset goes through here so that a hang ends the run as a mismatch.
    task automatic wait_edge(inout int n);
        @(posedge core_clk);
        #1;
        n++;
        if (n > 3000) begin
            check(48'h0, 48'h1, "wait bound");
            print_verdict();
        end
    endtask
    always @(posedge core_clk) begin
        if (wr_req === 1'b1) wi <= wi + 1;
        if (rd_req === 1'b1) ri <= ri + 1;
        if (txn_start === 1'b1) starts <= starts + 1;
        if (txn_end === 1'b1) ends <= ends + 1;
        if (wr_valid === 1'b1) begin
            check(d_wr, 8'hA0 + dwi[7:0], "device write byte");
            check(d_mask, cmd_die & dwi[0], "device mask");
            dwi <= dwi + 1;
        end
        if (rd_valid === 1'b1) begin
            check(h_rd, 8'h50 + hri[7:0], "host read byte");
            hri <= hri + 1;
        end
    end
    // Bit 47 is set on purpose: the read flag must replace it on the wire.
    task automatic xfer(input logic die, input logic rd, input logic ext, input int len,
            input logic acc);
        int n;
        int s0;
        int e0;
        s0 = starts;
        e0 = ends;
        wi = 0;
        ri = 0;
        dwi = 0;
        hri = 0;
        cmd_die = die;
        cmd_read = rd;
        cmd_len = len[15:0];
        cmd_ca = 48'h8123_4567_89AB;
        extra_latency = ext;
        cmd_valid = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1) wait_edge(n);
        wait_edge(n);
        cmd_valid = 1'b0;
        while (done !== 1'b1) wait_edge(n);
        // The device sees the select rise through its synchroniser, so its end pulse lags done.
        repeat (8) wait_edge(n);
        check(extra_seen, ext & acc, "latency flag");
        check(starts - s0, acc, "frame start");
        check(ends - e0, acc, "frame end");
        check(rd ? hri : dwi, acc ? len : 0, "byte count");
        if (acc) begin
            check(txn_die, die, "selected die");
            check(txn_read, rd, "read flag");
            check(txn_ca, {rd, 47'h0123_4567_89AB}, "command bytes");
        end
    endtask
    initial begin
        int n;
        n = 0;
        repeat (4) @(posedge core_clk);
        #1 reset = 1'b0;
        repeat (5) wait_edge(n);
        check(u_dmb_bus_if.power_on_reset_out_n, 1'b0, "reset out low");
        while (flash_ready !== 1'b1) wait_edge(n);
        check(n >= 20, 1'b1, "reset out length");
        check(u_dmb_bus_if.power_on_reset_out_n, 1'b1, "reset out released");
        xfer(DIE_FLASH, 1'b0, 1'b0, 4, 1'b1);
        xfer(DIE_DRAM, 1'b0, 1'b1, 4, 1'b1);
        xfer(DIE_FLASH, 1'b1, 1'b1, 4, 1'b1);
        xfer(DIE_DRAM, 1'b1, 1'b0, 3, 1'b1);
        xfer(DIE_DRAM, 1'b0, 1'b0, 0, 1'b1);
        flash_busy = 1'b1;
        repeat (3) wait_edge(n);
        flash_busy = 1'b0;
        repeat (4) wait_edge(n);
        check(u_dmb_bus_if.flash_interrupt_n, 1'b0, "interrupt raised");
        xfer(DIE_FLASH, 1'b0, 1'b0, 2, 1'b1);
        check(u_dmb_bus_if.flash_interrupt_n, 1'b1, "interrupt cleared");
        hw_reset_req = 1'b1;
        repeat (8) wait_edge(n);
        check(flash_ready, 1'b0, "flash held in reset");
        xfer(DIE_DRAM, 1'b1, 1'b0, 2, 1'b1);
        xfer(DIE_FLASH, 1'b0, 1'b0, 2, 1'b0);
        hw_reset_req = 1'b0;
        repeat (8) wait_edge(n);
        xfer(DIE_FLASH, 1'b1, 1'b0, 1, 1'b1);
        print_verdict();
    end
endmodule
